// ==== core/rst_ctrl_pkg.sv ====
// Purpose: constants and types for the reset source controller
// Assumes: 100 MHz sys_clk, classic Wishbone register access
// Notes:   offsets are byte addresses of 32-bit words
//
// Behaviour
// - pin low past minimum width forces reset, even with no clock; here the width is counted in sys_clk cycles, so a clock is needed.
// - on pin release, delay counter runs time-out before processor release.
// - trip level fuses: 111 off, 110/101/100 levels, others reserved.
// - supply-drop indication asserts reset at once; release waits time-out.
// - watchdog reset is one clock pulse; delay counts from its falling edge.
// - bit 3 set by watchdog reset; cleared by power-on or written zero.
// - bit 2 set by supply-drop reset; cleared by power-on or written zero.
// - bit 1 set by pin reset; cleared by power-on or written zero.
// - bit 0 set by power-on; only a written zero clears it.
// - reference powered only while detection on or reference-select set.
// - time-out length chosen by start-up-time and clock-select fuses.
// - power-on indication reasserts reset immediately, without delay.
`default_nettype none
package rst_ctrl_pkg;

  localparam logic [7:0] status_off      = 8'h00;
  localparam logic [7:0] ref_sel_off     = 8'h04;
  localparam logic [7:0] irq_mask_off    = 8'h08;
  localparam logic [7:0] level_off       = 8'h0c;
  localparam logic [7:0] irq_status_off  = 8'h10;

  localparam int watchdog_bit   = 3;
  localparam int supply_bit     = 2;
  localparam int pin_bit        = 1;
  localparam int power_on_bit   = 0;

  localparam logic [2:0] level_disabled = 3'h7;
  localparam logic [2:0] level_1v8      = 3'h6;
  localparam logic [2:0] level_2v7      = 3'h5;
  localparam logic [2:0] level_4v3      = 3'h4;

  // pin pulse must be seen this long to count as a reset
  localparam int min_pulse_ns     = 2500;
  localparam int clk_period_ns    = 10;
  localparam int min_pulse_cycles = (min_pulse_ns + clk_period_ns - 1)
                                    / clk_period_ns;
  localparam logic [3:0] status_reset = 4'h1;

  typedef enum {st_hold, st_count, st_run} seq_state_t;

  typedef struct packed {
    logic power_low;
    logic supply_low;
    logic pin_low;
    logic watchdog;
  } reset_req_t;

endpackage
`default_nettype wire

// ==== core/startup_delay.sv ====
// Purpose: start-up delay counter stretching the internal reset
// Assumes: sel picks one of 64 codes, giving 59 distinct time-out lengths
// Notes:   restarts whenever hold rises again
`timescale 1ns/1ns
`default_nettype none
module startup_delay import rst_ctrl_pkg::*; #(
  // the longest fuse choice, 64 << 15 plus 192, needs 22 bits
  parameter int          width = 22,
  parameter int          base  = 64
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       hold,
  input  wire logic [5:0] sel,
  output logic            done
);
  logic [width-1:0] count;
  logic [width-1:0] limit;

  always_comb begin
    limit = width'(base) << sel[5:2];
    limit = limit + (width'(base) * width'(sel[1:0]));
  end

  always_ff @(posedge sys_clk) begin
    if (rst || hold) begin
      count <= '0;
      done  <= 1'b0;
    end else if (!done) begin
      if (count >= limit) begin
        done <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end
endmodule // startup_delay
`default_nettype wire

// ==== core/reset_source_control.sv ====
// Purpose: reset source gathering, stretch, cause flags, reference power
// Assumes: comparator and pin inputs synchronous to sys_clk
// Notes:   wishbone classic slave, ack one cycle after request seen
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module reset_source_control import rst_ctrl_pkg::*; #(
  parameter int delay_width = 22
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        reset_pin_n,
  input  wire logic        supply_below_trip,
  input  wire logic        power_below_level,
  input  wire logic        watchdog_timeout,
  input  wire logic [2:0]  trip_level_fuses,
  input  wire logic [1:0]  startup_time_fuses,
  input  wire logic [3:0]  clock_select_fuses,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  output logic             internal_reset,
  output logic             watchdog_pulse,
  output logic             reference_power,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////
  reset_req_t         req;
  logic [11:0]        pin_count;
  logic               pin_valid;
  logic               supply_enabled;
  logic               any_source;
  logic               delay_done;
  logic [3:0]         reset_cause_status;
  logic [3:0]         irq_mask;
  logic               comparator_ref_select;
  logic               power_seen;
  logic               access;
  logic               wr_status;
  logic [3:0]         set_bits;
  logic [3:0]         irq_status;
  logic               rd_irq_status;
  logic               watchdog_prev;

  always_comb begin
    case (trip_level_fuses)
      level_1v8, level_2v7, level_4v3: supply_enabled = 1'b1;
      default:                         supply_enabled = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst || reset_pin_n) begin
      pin_count <= '0;
    end else if (!pin_valid) begin
      pin_count <= pin_count + 1'b1;
    end
  end
  assign pin_valid = pin_count >= 12'(min_pulse_cycles);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      watchdog_pulse <= 1'b0;
      watchdog_prev  <= 1'b0;
    end else begin
      // edge detect: a long expiry level still gives a single pulse
      watchdog_pulse <= watchdog_timeout && !watchdog_prev;
      watchdog_prev  <= watchdog_timeout;
    end
  end

  always_comb begin
    req.power_low  = power_below_level;
    req.supply_low = supply_enabled && supply_below_trip;
    req.pin_low    = pin_valid && !reset_pin_n;
    req.watchdog   = watchdog_pulse;
  end
  assign any_source = |req;

  ////////////////////////////////////////////////////////////////////////
  // delay after release
  startup_delay #(
    .width (delay_width)
  ) u_startup_delay (
    .sys_clk (sys_clk),
    .rst     (rst),
    .hold    (any_source),
    .sel     ({clock_select_fuses, startup_time_fuses}),
    .done    (delay_done)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      internal_reset <= 1'b1;
    end else if (req.power_low) begin
      internal_reset <= 1'b1;
    end else begin
      internal_reset <= any_source || !delay_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign access    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr_status = access && wb_we_i && wb_adr_i == status_off
                     && wb_sel_i[0];
  assign rd_irq_status = access && !wb_we_i && wb_adr_i == irq_status_off;

  always_comb begin
    set_bits = '0;
    set_bits[watchdog_bit] = req.watchdog;
    set_bits[supply_bit]   = req.supply_low;
    set_bits[pin_bit]      = req.pin_low;
    set_bits[power_on_bit] = req.power_low && !power_seen;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      power_seen <= 1'b0;
    end else begin
      power_seen <= req.power_low;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reset_cause_status <= status_reset;
    end else if (req.power_low) begin
      // power-on clears the others but keeps its own flag set
      reset_cause_status <= status_reset;
    end else begin
      if (wr_status) begin
        reset_cause_status <= (reset_cause_status & wb_dat_i[3:0])
                              | set_bits;
      end else begin
        reset_cause_status <= reset_cause_status | set_bits;
      end
    end
  end

  // interrupt copy of the causes; a read clears it so that the cause
  // flags themselves only clear by a written zero or power-on, set beats clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_status <= '0;
    end else if (rd_irq_status) begin
      irq_status <= set_bits;
    end else begin
      irq_status <= irq_status | set_bits;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_mask              <= '0;
      comparator_ref_select <= 1'b0;
    end else if (access && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == irq_mask_off) begin
        irq_mask <= wb_dat_i[3:0];
      end
      if (wb_adr_i == ref_sel_off) begin
        comparator_ref_select <= wb_dat_i[0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reference_power <= 1'b0;
      irq             <= 1'b0;
    end else begin
      reference_power <= supply_enabled || comparator_ref_select;
      irq             <= |(irq_status & irq_mask);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      if (access) begin
        case (wb_adr_i)
          status_off: begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= {28'h0, reset_cause_status};
          end
          ref_sel_off: begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= {31'h0, comparator_ref_select};
          end
          irq_mask_off: begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= {28'h0, irq_mask};
          end
          level_off: begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= {29'h0, trip_level_fuses};
          end
          irq_status_off: begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= {28'h0, irq_status};
          end
          default: begin
            wb_err_o <= 1'b1;
            wb_dat_o <= '0;
          end
        endcase
      end
    end
  end

endmodule // reset_source_control
`default_nettype wire

// ==== bench/rst_ctrl_sva.sv ====
// Purpose: port assertions for reset source control
// Assumes: start-up fuses give a delay of at least 64 cycles
// Notes: counters saturate at 255
`timescale 1ns/1ns
`default_nettype none
module rst_ctrl_sva (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       reset_pin_n,
  input wire logic       supply_below_trip,
  input wire logic       power_below_level,
  input wire logic       watchdog_timeout,
  input wire logic [2:0] trip_level_fuses,
  input wire logic       internal_reset,
  input wire logic       watchdog_pulse,
  input wire logic       reference_power
);
  logic [7:0] low_cnt;
  logic [7:0] quiet_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge sys_clk) begin
    if (rst || reset_pin_n) low_cnt <= 8'h00;
    else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h01;
  end
  // raw inputs lead the registered internal_reset, so a small slack is kept
  always_ff @(posedge sys_clk) begin
    if (rst || !reset_pin_n || supply_below_trip || power_below_level
        || watchdog_pulse) quiet_cnt <= 8'h00;
    else if (quiet_cnt != 8'hff) quiet_cnt <= quiet_cnt + 8'h01;
  end
  AST_WD_ONE: assert property (watchdog_pulse |=> !watchdog_pulse)
    else $error("wd pulse too long");
  AST_WD_RISE: assert property ($rose(watchdog_timeout)
    |-> ##[1:2] watchdog_pulse) else $error("no wd pulse");
  AST_WD_RST: assert property (watchdog_pulse
    |-> ##[0:2] internal_reset) else $error("wd no reset");
  AST_DROP: assert property (supply_below_trip && trip_level_fuses
    inside {[3'h4:3'h6]} |-> ##[1:3] internal_reset) else $error("drop");
  AST_POR: assert property (power_below_level
    |-> ##[1:3] internal_reset) else $error("power-on no reset");
  AST_PIN: assert property (low_cnt == 8'hff |-> internal_reset)
    else $error("pin no reset");
  AST_DELAY: assert property ($fell(internal_reset)
    |-> quiet_cnt >= 8'd62) else $error("release too early");
  AST_REF: assert property (trip_level_fuses
    inside {[3'h4:3'h6]} |=> reference_power) else $error("ref off");
endmodule // rst_ctrl_sva
//////////////////////////////////////////////////////////////////////////////
bind reset_source_control rst_ctrl_sva u_rst_ctrl_sva (.sys_clk, .rst,
  .reset_pin_n, .supply_below_trip, .power_below_level, .watchdog_timeout,
  .trip_level_fuses, .internal_reset, .watchdog_pulse, .reference_power);
`default_nettype wire

// ==== bench/src_model.sv ====
// Purpose: reset pin driver and supply comparator model
// Assumes: called from bench tasks
// Notes: levels change just after an edge
`timescale 1ns/1ns
`default_nettype none
module src_model (
  input  wire logic sys_clk,
  output logic      reset_pin_n = 1'b1,
  output logic      supply_below_trip = 1'b0,
  output logic      power_below_level = 1'b0
);
  task automatic dip(input int s, input int n);
    @(posedge sys_clk);
    {power_below_level, supply_below_trip, reset_pin_n} <= 3'h1 ^ (3'h1 << s);
    repeat (n) @(posedge sys_clk);
    {power_below_level, supply_below_trip, reset_pin_n} <= 3'h1;
  endtask
endmodule // src_model
`default_nettype wire

// ==== bench/test_reset_source_control.sv ====
// Purpose: self-checking bench for reset source control
// Assumes: start-up fuses zero until t_delay sets them to 1
// Notes: cause flags clear by a written zero, irq status by a read
`timescale 1ns/1ns
`default_nettype none
module test_reset_source_control;
  import rst_ctrl_pkg::*;
  logic        sys_clk = 1'b0, rst = 1'b1, watchdog_timeout = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, er;
  logic [1:0]  startup_time_fuses = 2'h0;
  logic [3:0]  clock_select_fuses = 4'h0, wb_sel_i = 4'hf;
  logic [2:0]  trip_level_fuses = 3'h7;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_ack_o, wb_err_o, internal_reset, watchdog_pulse, irq;
  logic        reference_power, reset_pin_n, supply_below_trip;
  logic        power_below_level;
  int          failures = 0, compares = 0;
  src_model u_src_model (.sys_clk, .reset_pin_n, .supply_below_trip,
    .power_below_level);
  reset_source_control u_reset_source_control (.sys_clk, .rst,
    .reset_pin_n, .supply_below_trip, .power_below_level,
    .watchdog_timeout, .trip_level_fuses, .startup_time_fuses,
    .clock_select_fuses, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
    .internal_reset, .watchdog_pulse, .reference_power, .irq);
  initial forever #5 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) break;
    end
    rd = wb_dat_o;
    er = wb_err_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (i == 20) failures++;
    if (i == 20) tally_and_finish();
  endtask
  // bounded wait for the processor release
  task automatic wait_run;
    int i;
    for (i = 0; i < 3000 && internal_reset !== 1'b0; i++) @(posedge sys_clk);
    if (i == 3000) failures++;
    if (i == 3000) tally_and_finish();
  endtask
  task automatic t_power;
    wait_run();
    for (int k = 0; k < 3; k++) begin
      if (k == 2) u_src_model.dip(2, 20);
      wait_run();
      wb(1'b0, status_off, 32'h0);
      chk("power flag", rd, k == 1 ? 32'h0 : 32'h1);
      wb(1'b0, status_off, 32'h0);
      chk("flag kept", rd, k == 1 ? 32'h0 : 32'h1);
      wb(1'b1, status_off, 32'h0);
    end
    $display("t_power done");
  endtask
  task automatic t_wd;
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      watchdog_timeout <= 1'b1;
      repeat (4) @(posedge sys_clk);
      watchdog_timeout <= 1'b0;
      wait_run();
      if (k == 1) wb(1'b1, status_off, 32'h0);
      wb(1'b0, status_off, 32'h0);
      chk("wd flag", rd, k ? 32'h0 : 32'h8);
    end
    $display("t_wd done");
  endtask
  task automatic t_pin;
    wb(1'b0, irq_status_off, 32'h0);
    chk("irq events", rd, 32'h9);
    wb(1'b1, irq_mask_off, 32'hf);
    u_src_model.dip(0, 100);
    chk("short pin", {31'h0, internal_reset}, 32'h0);
    u_src_model.dip(0, 300);
    wait_run();
    chk("irq set", {31'h0, irq}, 32'h1);
    wb(1'b0, status_off, 32'h0);
    chk("pin flag", rd, 32'h2);
    wb(1'b1, status_off, 32'h0);
    wb(1'b0, irq_status_off, 32'h0);
    chk("irq pin", rd, 32'h2);
    repeat (3) @(posedge sys_clk);
    chk("irq clear", {31'h0, irq}, 32'h0);
    $display("t_pin done");
  endtask
  task automatic t_bod;
    logic en;
    for (int k = 3; k < 8; k++) begin
      en = k inside {[4:6]};
      trip_level_fuses <= 3'(k);
      repeat (3) @(posedge sys_clk);
      chk("ref power", {31'h0, reference_power}, {31'h0, en});
      u_src_model.dip(1, 10);
      wait_run();
      wb(1'b0, status_off, 32'h0);
      chk("drop flag", rd, {29'h0, en, 2'h0});
      wb(1'b1, status_off, 32'h0);
    end
    wb(1'b0, level_off, 32'h0);
    chk("level", rd, 32'h7);
    wb(1'b1, ref_sel_off, 32'h1);
    repeat (7000) @(posedge sys_clk);
    chk("ref sel", {31'h0, reference_power}, 32'h1);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {31'h0, er}, 32'h1);
    $display("t_bod done");
  endtask
  // longer fuse delay, restarted by a second power dip mid count
  task automatic t_delay;
    int n;
    startup_time_fuses <= 2'h1;
    u_src_model.dip(2, 10);
    repeat (50) @(posedge sys_clk);
    chk("held", {31'h0, internal_reset}, 32'h1);
    u_src_model.dip(2, 10);
    for (n = 0; n < 3000 && internal_reset !== 1'b0; n++) @(posedge sys_clk);
    // 64 + 64 delay cycles, plus 3 edges from release to the seen level
    chk("delay", n, 32'h83);
    if (n == 3000) tally_and_finish();
    wb(1'b0, status_off, 32'h0);
    chk("por again", rd, 32'h1);
    $display("t_delay done");
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_power();
    t_wd();
    t_pin();
    t_bod();
    t_delay();
    tally_and_finish();
  end
endmodule // test_reset_source_control
`default_nettype wire
